// [verilog/tfm_pkg.sv]
// Contract
// - An 8-bit read/write filter configuration register sits at control address 5.
// - Rate code 0 or 1 gives complex output at the input rate, and codes 2 to 7 divide it by 2 to 64.
// - In real mode, rate codes 2 to 7 give the input rate down to the input rate divided by 32.
// - Bit 4 selects real samples with a spectrum from zero up to half the output rate.
// - In complex mode, bit 5 moves the spectrum so that it is centred at half the output rate.
// - In complex mode, bit 6 set mirrors the spectrum about zero.
// - In real mode, bit 6 clear mirrors the spectrum about a quarter of the output rate.
// - Bit 7 swaps the sample input for an internal ramp that runs from -2048 to +2047 and wraps.
package tfm_pkg;
    localparam int          ADDR_W        = 4;
    localparam int          DATA_W        = 8;
    localparam int          SAMPLE_W      = 12;
    localparam logic [3:0]  FILT_CFG_ADDR = 4'h5;
    localparam logic [7:0]  FILT_CFG_RST  = 8'h00;
    localparam int          RATE_LSB      = 0;
    localparam int          RATE_W        = 3;
    localparam int          REAL_BIT      = 4;
    localparam int          OFFSET_BIT    = 5;
    localparam int          MIRROR_BIT    = 6;
    localparam int          RAMP_BIT      = 7;
    localparam logic [7:0]  CFG_RW_MASK   = 8'hF7;
    localparam logic [11:0] RAMP_START    = 12'h800;
    localparam int          DIV_W         = 6;
endpackage

// [verilog/tfm_rate_div.sv]
// Turns a rate code into a one-cycle output strobe at the selected rate
module tfm_rate_div
    import tfm_pkg::*;
#(
    parameter int CNT_W = tfm_pkg::DIV_W
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Control
    input  wire logic [2:0]       rate_divide_select_i,
    input  wire logic             real_mode_i,
    // Strobe
    output logic                  out_stb_o
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             stb;
    } tfm_div_s;

    tfm_div_s st_q;
    tfm_div_s st_d;
    logic [CNT_W-1:0] term;

    // Exponent: complex is code-1 for codes 2..7, real is one less
    always_comb begin
        logic [2:0] expo;
        expo = 3'h0;
        if (rate_divide_select_i >= 3'h2) begin
            expo = rate_divide_select_i - 3'h1;
            if (real_mode_i) begin
                expo = rate_divide_select_i - 3'h2;
            end
        end
        // Real with codes 0/1 is undefined; it falls back to the input rate
        term = CNT_W'((7'h01 << expo) - 7'h01);
    end

    // Counter wraps on terminal count and emits the strobe
    always_comb begin
        st_d = st_q;
        st_d.stb = (st_q.cnt >= term);
        st_d.cnt = (st_q.cnt >= term) ? '0 : st_q.cnt + 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign out_stb_o = st_q.stb;
endmodule

// [verilog/tfm_filter_mode.sv]
// Filter mode configuration: register port, input select, spectral format, rate strobe
module tfm_filter_mode
    import tfm_pkg::*;
(
    // Clock and reset
    input  wire logic                         CLOCK_I,
    input  wire logic                         RST_I,
    // Control bus
    input  wire logic                         CS_N_I,
    input  wire logic                         RD_WR_N_I,
    input  wire logic [tfm_pkg::ADDR_W-1:0]   ADDR_I,
    input  wire logic [tfm_pkg::DATA_W-1:0]   DATA_I,
    output logic      [tfm_pkg::DATA_W-1:0]   DATA_O,
    output logic                              DATA_OE_O,
    // Sample input
    input  wire logic [tfm_pkg::SAMPLE_W-1:0] SAMPLE_I,
    // Processed stream
    output logic      [tfm_pkg::SAMPLE_W-1:0] CHAIN_I_O,
    output logic      [tfm_pkg::SAMPLE_W-1:0] CHAIN_Q_O,
    output logic                              OUT_STB_O,
    // Decoded configuration
    output logic      [2:0]                   RATE_DIVIDE_SELECT_O,
    output logic                              REAL_MODE_O,
    output logic                              OFFSET_MODE_O,
    output logic                              MIRROR_O,
    output logic                              TEST_RAMP_SELECT_O
);
    import tfm_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0]   cfg;
        logic                cs_n;
        logic [DATA_W-1:0]   rdata;
        logic                oe;
        logic [SAMPLE_W-1:0] ramp;
        logic [1:0]          phase;
        logic [SAMPLE_W-1:0] i_out;
        logic [SAMPLE_W-1:0] q_out;
        logic                stb;
    } tfm_state_s;

    tfm_state_s st_q;
    tfm_state_s st_d;
    logic       div_stb;
    logic       mirror_act;

    tfm_rate_div #(
        .CNT_W (DIV_W)
    ) u_div (
        .clk_i                (CLOCK_I),
        .rst_i                (RST_I),
        .rate_divide_select_i (st_q.cfg[RATE_LSB +: RATE_W]),
        .real_mode_i          (st_q.cfg[REAL_BIT]),
        .out_stb_o            (div_stb)
    );

    // Mirror polarity flips in real mode: there a clear bit mirrors
    assign mirror_act = st_q.cfg[REAL_BIT] ? ~st_q.cfg[MIRROR_BIT]
                                           : st_q.cfg[MIRROR_BIT];

    always_comb begin
        logic [SAMPLE_W-1:0] x;
        logic [SAMPLE_W-1:0] ii;
        logic [SAMPLE_W-1:0] qq;
        x  = '0;
        ii = '0;
        qq = '0;
        st_d = st_q;
        st_d.cs_n = CS_N_I;
        // Write loads on the falling strobe edge; bit 3 is kept but inert
        if (!CS_N_I && st_q.cs_n && !RD_WR_N_I && ADDR_I == FILT_CFG_ADDR) begin
            st_d.cfg = DATA_I & CFG_RW_MASK | (DATA_I & ~CFG_RW_MASK);
        end
        // Read drives the bus while strobe is low; other addresses read zero here
        st_d.oe    = !CS_N_I && RD_WR_N_I;
        st_d.rdata = (ADDR_I == FILT_CFG_ADDR) ? st_q.cfg : '0;
        // Ramp steps once per sample clock, wrapping +2047 to -2048
        if (st_q.cfg[RAMP_BIT]) begin
            st_d.ramp = st_q.ramp + 1'b1;
        end else begin
            st_d.ramp = RAMP_START;
        end
        x = st_q.cfg[RAMP_BIT] ? st_q.ramp : SAMPLE_I;
        // Format: in complex mode, offset negates every other output sample, a half-turn per sample (fs/2 shift)
        ii = x;
        qq = '0;
        // Phase counts output samples, so the sign pattern follows the output rate
        if (div_stb) begin
            st_d.phase = st_q.phase + 2'h1;
        end
        if (!st_q.cfg[REAL_BIT] && st_q.cfg[OFFSET_BIT] && st_q.phase[0]) begin
            ii = -x;
        end
        // Real mirror about fs/4 alternates sign; complex mirror is conjugation
        if (mirror_act) begin
            if (st_q.cfg[REAL_BIT]) begin
                ii = st_q.phase[0] ? -ii : ii;
            end else begin
                qq = -qq;
            end
        end
        if (st_q.cfg[REAL_BIT]) begin
            qq = '0;
        end
        if (div_stb) begin
            st_d.i_out = ii;
            st_d.q_out = qq;
        end
        st_d.stb = div_stb;
    end

    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            st_q      <= '0;
            st_q.cfg  <= FILT_CFG_RST;
            st_q.cs_n <= 1'b1;
            st_q.ramp <= RAMP_START;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign DATA_O               = st_q.rdata;
    assign DATA_OE_O            = st_q.oe;
    assign CHAIN_I_O            = st_q.i_out;
    assign CHAIN_Q_O            = st_q.q_out;
    assign OUT_STB_O            = st_q.stb;
    assign RATE_DIVIDE_SELECT_O = st_q.cfg[RATE_LSB +: RATE_W];
    assign REAL_MODE_O          = st_q.cfg[REAL_BIT];
    assign OFFSET_MODE_O        = st_q.cfg[OFFSET_BIT];
    assign MIRROR_O             = st_q.cfg[MIRROR_BIT];
    assign TEST_RAMP_SELECT_O   = st_q.cfg[RAMP_BIT];
endmodule

// [tb/tfm_filter_mode_properties.sv]
// Watches the control port and the decoded configuration of the filter mode block
module tfm_chk (
    // Clock, reset, control bus
    input wire logic        CLOCK_I, RST_I, CS_N_I, RD_WR_N_I, DATA_OE_O, OUT_STB_O,
    input wire logic [3:0]  ADDR_I,
    input wire logic [7:0]  DATA_I, DATA_O,
    // Stream and configuration
    input wire logic [11:0] CHAIN_I_O,
    input wire logic [2:0]  RATE_DIVIDE_SELECT_O,
    input wire logic        REAL_MODE_O, OFFSET_MODE_O, MIRROR_O, TEST_RAMP_SELECT_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    logic [6:0] cfg;
    // Bit 3 has no output, so the view skips it
    assign cfg = {TEST_RAMP_SELECT_O, MIRROR_O, OFFSET_MODE_O, REAL_MODE_O, RATE_DIVIDE_SELECT_O};
    sequence s_wr; $fell(CS_N_I) && !RD_WR_N_I && ADDR_I == 4'h5; endsequence
    sequence s_rd; !CS_N_I && RD_WR_N_I; endsequence
    sequence s_ramp; (cfg == 7'h40)[*6]; endsequence
    a_write_loads_cfg: assert property (
        s_wr |=> cfg == {$past(DATA_I[7:4]), $past(DATA_I[2:0])}) else $error("write lost");
    a_read_returns_cfg: assert property (
        s_rd ##0 ADDR_I == 4'h5 |=> (DATA_O & 8'hF7) == {cfg[6:3], 1'b0, cfg[2:0]})
        else $error("read value wrong");
    a_unmapped_reads_zero: assert property (
        s_rd ##0 ADDR_I != 4'h5 |=> DATA_O == 8'h00) else $error("unmapped read");
    a_no_stray_write: assert property (
        !CS_N_I && (ADDR_I != 4'h5 || !$past(CS_N_I)) |=> $stable(cfg)) else $error("stray write");
    a_read_drives_bus: assert property (s_rd |=> DATA_OE_O) else $error("bus not driven");
    a_idle_bus_off: assert property (CS_N_I |=> !DATA_OE_O) else $error("bus driven idle");
    a_ramp_steps_one: assert property (
        s_ramp |-> CHAIN_I_O == $past(CHAIN_I_O) + 12'h001) else $error("ramp step");
    a_full_rate_strobe: assert property (
        (RATE_DIVIDE_SELECT_O <= 3'h1 && !REAL_MODE_O)[*4] |-> OUT_STB_O) else $error("rate");
endmodule

// [tb/tfm_host.sv]
// Host on the parallel control bus; it changes lines only at falling edges
module tfm_host (
    input  wire logic       clk_i,
    output logic            cs_n_o, rd_wr_n_o,
    output logic [3:0]      addr_o,
    output logic [7:0]      data_o,
    input  wire logic [7:0] rdata_i,
    input  wire logic       oe_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial begin
        cs_n_o = 1'b1; rd_wr_n_o = 1'b1; addr_o = 4'h0; data_o = 8'h00;
    end
    // Strobe low for one edge; released data shows the inverse so stale bits never match
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk_i);
        cs_n_o = 1'b0; rd_wr_n_o = 1'b0; addr_o = a; data_o = d;
        @(negedge clk_i);
        cs_n_o = 1'b1; data_o = ~d;
    endtask
    // Strobe held over two edges so the registered answer is settled when taken
    task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic oe);
        @(negedge clk_i);
        cs_n_o = 1'b0; rd_wr_n_o = 1'b1; addr_o = a;
        repeat (2) @(negedge clk_i);
        d = rdata_i; oe = oe_i;
        cs_n_o = 1'b1;
    endtask
endmodule

// [tb/tb_tfm_filter_mode.sv]
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tb_tfm_filter_mode;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CLOCK_I, RST_I, CS_N_I, RD_WR_N_I, DATA_OE_O, OUT_STB_O, oe_v, done;
    logic        REAL_MODE_O, OFFSET_MODE_O, MIRROR_O, TEST_RAMP_SELECT_O;
    logic [3:0]  ADDR_I;
    logic [7:0]  DATA_I, DATA_O, rd_v;
    logic [11:0] SAMPLE_I, CHAIN_I_O, CHAIN_Q_O, a_s, b_s;
    logic [2:0]  RATE_DIVIDE_SELECT_O;
    int          fails, check_count, n;
    tfm_filter_mode dut_u (.*);
    tfm_host host_u (.clk_i(CLOCK_I), .cs_n_o(CS_N_I), .rd_wr_n_o(RD_WR_N_I), .addr_o(ADDR_I),
        .data_o(DATA_I), .rdata_i(DATA_O), .oe_i(DATA_OE_O));
    // 100 MHz clock
    initial begin
        CLOCK_I = 1'b0;
        forever #5 CLOCK_I = ~CLOCK_I;
    end
    task automatic final_report;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Two successive outputs of a fixed input: same sign, or alternating sign
    task automatic mode(input logic [7:0] c, input logic alt);
        host_u.wr(4'h5, c);
        repeat (8) @(negedge CLOCK_I);
        a_s = CHAIN_I_O;
        @(negedge CLOCK_I);
        b_s = CHAIN_I_O;
        `CHK(b_s, alt ? -a_s : a_s)
        `CHK(a_s[11] ? -a_s : a_s, 12'h123)
        `CHK(CHAIN_Q_O, 12'h000)
    endtask
    // Main sequence; a second reset before the ramp run checks its start value
    initial begin
        RST_I = 1'b1; SAMPLE_I = 12'h123; fails = 0; check_count = 0;
        repeat (3) @(negedge CLOCK_I);
        RST_I = 1'b0;
        for (int i = 0; i < 8; i++) begin
            host_u.wr(4'h5, (8'h01 << i) | 8'h02);
            host_u.rd(4'h5, rd_v, oe_v);
            `CHK(rd_v, (8'h01 << i) | 8'h02)
        end
        host_u.wr(4'h4, 8'h3C);
        host_u.rd(4'h9, rd_v, oe_v);
        `CHK(rd_v, 8'h00)
        `CHK(oe_v, 1'b1)
        host_u.rd(4'h5, rd_v, oe_v);
        `CHK(rd_v, 8'h82)
        for (int m = 0; m < 2; m++) begin
            for (int c = 2 * m; c < 8; c++) begin
                host_u.wr(4'h5, 8'(c + 16 * m));
                repeat (8) @(negedge CLOCK_I);
                n = 0;
                repeat (128) begin
                    @(negedge CLOCK_I);
                    n += int'(OUT_STB_O === 1'b1);
                end
                `CHK(n, 128 >> (c < 2 ? 0 : c - 1 - m))
            end
        end
        mode(8'h00, 1'b0);
        mode(8'h40, 1'b0);
        mode(8'h20, 1'b1);
        mode(8'h12, 1'b1);
        mode(8'h52, 1'b0);
        RST_I = 1'b1;
        repeat (3) @(negedge CLOCK_I);
        RST_I = 1'b0;
        host_u.wr(4'h5, 8'h80);
        repeat (8) @(negedge CLOCK_I);
        `CHK(CHAIN_I_O[11:4], 8'h80)
        done = 1'b0;
        for (int k = 0; k < 4200 && !done; k++) begin
            a_s = CHAIN_I_O;
            @(negedge CLOCK_I);
            `CHK(CHAIN_I_O, a_s + 12'h001)
            done = (a_s === 12'h7FF);
        end
        `CHK(done, 1'b1)
        final_report();
    end
endmodule
bind tfm_filter_mode tfm_chk chk_u (.*);
